// *** ocd_channel_two.sv ***
module ocd_channel_two (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Register port from the serial front end.
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  // Nonvolatile page load.
  input wire logic NVM_LOAD_I,
  input wire logic [13:0] NVM_DIVIDER_I,
  input wire logic [8:0] NVM_RESERVED_I,
  // Clock and sync pins, sampled.
  input wire logic PRESCALER_CLOCK_FIRST_I,
  input wire logic PRESCALER_CLOCK_SECOND_I,
  input wire logic REFERENCE_CLOCK_I,
  input wire logic CH1_DIVIDED_I,
  input wire logic CH3_DIVIDED_I,
  input wire logic SYNC_I,
  // Output buffer controls.
  output logic OUT_TRUE_O,
  output logic OUT_COMP_O,
  output logic TRUE_LEG_EN_O,
  output logic COMP_LEG_EN_O,
  output logic [2:0] BUFFER_FORMAT_O,
  // Divider status and divided clock.
  output logic DIVIDER_POWERED_O,
  output logic CH2_DIVIDED_O
);

  // ==========================================================================
  // Pin synchronisers.
  // Order: sync, ch3, ch1, reference, second, first.
  logic [5:0] pin_s1, pin_s2, next_pin_s1, next_pin_s2;

  // Stage one is read only by stage two.
  always_comb begin
    next_pin_s1 = {SYNC_I, CH3_DIVIDED_I, CH1_DIVIDED_I, REFERENCE_CLOCK_I,
                   PRESCALER_CLOCK_SECOND_I, PRESCALER_CLOCK_FIRST_I};
    next_pin_s2 = pin_s1;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
    end
  end

  // ==========================================================================
  // Register file.
  logic [15:0] reg_reserved, reg_divider, reg_output, next_reserved, next_divider, next_output;
  logic [15:0] next_rdata;

  // A host write in the same cycle as a page load wins, as it is the newer value.
  always_comb begin
    next_reserved = reg_reserved;
    next_divider = reg_divider;
    next_output = reg_output;
    next_rdata = REG_RDATA_O;
    if (NVM_LOAD_I) begin
      next_reserved[ocd_pkg::RESERVED_EX_W-1:0] = NVM_RESERVED_I;
      next_divider[ocd_pkg::DIVIDER_VALUE_LSB +: ocd_pkg::DIVIDER_VALUE_W] = NVM_DIVIDER_I;
    end
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ocd_pkg::ADDR_RESERVED_CONFIG: next_reserved = REG_WDATA_I;
        ocd_pkg::ADDR_DIVIDER_SETUP: next_divider = REG_WDATA_I;
        ocd_pkg::ADDR_OUTPUT_SETUP: next_output = REG_WDATA_I;
        default: next_reserved = next_reserved;
      endcase
    end
    // Unmapped addresses read as zero.
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ocd_pkg::ADDR_RESERVED_CONFIG: next_rdata = reg_reserved;
        ocd_pkg::ADDR_DIVIDER_SETUP: next_rdata = reg_divider;
        ocd_pkg::ADDR_OUTPUT_SETUP: next_rdata = reg_output;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      reg_reserved <= ocd_pkg::RESET_RESERVED_CONFIG;
      reg_divider <= ocd_pkg::RESET_DIVIDER_SETUP;
      reg_output <= ocd_pkg::RESET_OUTPUT_SETUP;
      REG_RDATA_O <= 16'h0000;
    end else begin
      reg_reserved <= next_reserved;
      reg_divider <= next_divider;
      reg_output <= next_output;
      REG_RDATA_O <= next_rdata;
    end
  end

  // Field views.
  logic [1:0] divider_source_select, single_ended_polarity, output_source_route;
  logic [13:0] divider_value;
  logic [4:0] restart_delay_count;
  logic [2:0] buffer_format_select;
  logic sync_participation, parked_level_select, output_silence;
  assign divider_source_select = reg_divider[ocd_pkg::SOURCE_SELECT_LSB +: 2];
  assign divider_value = reg_divider[ocd_pkg::DIVIDER_VALUE_LSB +: ocd_pkg::DIVIDER_VALUE_W];
  assign restart_delay_count = reg_output[ocd_pkg::RESTART_DELAY_LSB +: ocd_pkg::RESTART_DELAY_W];
  assign sync_participation = reg_output[ocd_pkg::SYNC_PARTICIPATION_BIT];
  assign parked_level_select = reg_output[ocd_pkg::PARKED_LEVEL_BIT];
  assign output_silence = reg_output[ocd_pkg::OUTPUT_SILENCE_BIT];
  assign single_ended_polarity = reg_output[ocd_pkg::POLARITY_LSB +: 2];
  assign buffer_format_select = reg_output[ocd_pkg::FORMAT_LSB +: 3];
  assign output_source_route = reg_output[ocd_pkg::ROUTE_LSB +: 2];

  // ==========================================================================
  // Divider.
  ocd_pkg::ocd_state_t state, next_state;
  logic [13:0] div_cnt, next_div_cnt, half_value;
  logic [4:0] delay_cnt, next_delay_cnt;
  logic div_clk, next_div_clk, src_prev, sync_prev, src_level, src_edge, sync_rise;

  // Source mux; the unlisted code 2 gives no clock at all.
  always_comb begin
    case (ocd_pkg::ocd_source_t'(divider_source_select))
      ocd_pkg::SRC_PRESCALER_FIRST: src_level = pin_s2[0];
      ocd_pkg::SRC_PRESCALER_SECOND: src_level = pin_s2[1];
      ocd_pkg::SRC_REFERENCE: src_level = pin_s2[2];
      default: src_level = 1'b0;
    endcase
  end

  assign src_edge = src_level & ~src_prev;
  assign sync_rise = pin_s2[5] & ~sync_prev;
  assign half_value = divider_value >> 1;

  // Counter wraps at value minus one; the clock is high for the lower half.
  always_comb begin
    next_state = state;
    next_div_cnt = div_cnt;
    next_delay_cnt = delay_cnt;
    next_div_clk = div_clk;
    if (divider_value == 14'h0000) begin
      next_state = ocd_pkg::ST_OFF;
      next_div_cnt = 14'h0000;
      next_div_clk = 1'b0;
    end else if (sync_rise && sync_participation) begin
      next_state = ocd_pkg::ST_HOLD;
      next_delay_cnt = restart_delay_count;
      next_div_cnt = 14'h0000;
      next_div_clk = 1'b0;
    end else begin
      case (state)
        ocd_pkg::ST_OFF: begin
          next_state = ocd_pkg::ST_RUN;
          next_div_cnt = 14'h0000;
        end
        ocd_pkg::ST_RUN: begin
          if (divider_value == 14'h0001) begin
            next_div_clk = src_level;
          end else if (src_edge) begin
            if (div_cnt >= 14'(divider_value - 14'h0001)) begin
              next_div_cnt = 14'h0000;
            end else begin
              next_div_cnt = 14'(div_cnt + 14'h0001);
            end
            next_div_clk = (next_div_cnt < half_value);
          end
        end
        ocd_pkg::ST_HOLD: begin
          // Each delay count is one rising edge of the selected source clock.
          if (delay_cnt == 5'h00) begin
            next_state = ocd_pkg::ST_RUN;
          end else if (src_edge) begin
            next_delay_cnt = 5'(delay_cnt - 5'h01);
          end
        end
        default: next_state = ocd_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ocd_pkg::ST_OFF;
      div_cnt <= 14'h0000;
      delay_cnt <= 5'h00;
      div_clk <= 1'b0;
      src_prev <= 1'b0;
      sync_prev <= 1'b0;
      DIVIDER_POWERED_O <= 1'b0;
      CH2_DIVIDED_O <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      delay_cnt <= next_delay_cnt;
      div_clk <= next_div_clk;
      src_prev <= src_level;
      sync_prev <= pin_s2[5];
      DIVIDER_POWERED_O <= (next_state != ocd_pkg::ST_OFF);
      CH2_DIVIDED_O <= next_div_clk;
    end
  end

  // ==========================================================================
  // Output mux, polarity, silencing and buffer format.
  logic routed, next_true, next_comp, next_true_en, next_comp_en, single_ended;
  // Polarity only matters for single-ended legs; the differential pair is always
  // complementary so that the receiver never sees a common-mode step.
  always_comb begin
    case (ocd_pkg::ocd_route_t'(output_source_route))
      ocd_pkg::ROUTE_CHANNEL_ONE: routed = pin_s2[3];
      ocd_pkg::ROUTE_CHANNEL_TWO: routed = div_clk;
      ocd_pkg::ROUTE_CHANNEL_THREE: routed = pin_s2[4];
      default: routed = 1'b0;
    endcase
    single_ended = (buffer_format_select >= 3'(ocd_pkg::FMT_SINGLE_ENDED_BOTH_LEGS));
    if (single_ended) begin
      next_true = routed ^ single_ended_polarity[1];
      next_comp = routed ^ single_ended_polarity[0];
    end else begin
      next_true = routed;
      next_comp = ~routed;
    end
    if (output_silence) begin
      next_true = parked_level_select;
      next_comp = ~parked_level_select;
    end
    case (ocd_pkg::ocd_format_t'(buffer_format_select))
      ocd_pkg::FMT_OFF: begin
        next_true_en = 1'b0;
        next_comp_en = 1'b0;
        next_true = 1'b0;
        next_comp = 1'b0;
      end
      ocd_pkg::FMT_SINGLE_ENDED_TRUE_LEG: begin
        next_true_en = 1'b1;
        next_comp_en = 1'b0;
      end
      ocd_pkg::FMT_SINGLE_ENDED_COMPLEMENT_LEG: begin
        next_true_en = 1'b0;
        next_comp_en = 1'b1;
      end
      default: begin
        next_true_en = 1'b1;
        next_comp_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_TRUE_O <= 1'b0;
      OUT_COMP_O <= 1'b0;
      TRUE_LEG_EN_O <= 1'b0;
      COMP_LEG_EN_O <= 1'b0;
      BUFFER_FORMAT_O <= 3'h0;
    end else begin
      OUT_TRUE_O <= next_true;
      OUT_COMP_O <= next_comp;
      TRUE_LEG_EN_O <= next_true_en;
      COMP_LEG_EN_O <= next_comp_en;
      BUFFER_FORMAT_O <= buffer_format_select;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking ocd_cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  power_down_a: assert property (
    divider_value == 14'h0000 |=> !DIVIDER_POWERED_O && !CH2_DIVIDED_O && state == ocd_pkg::ST_OFF)
    else $error("Divider not powered down at value zero.");
  count_wrap_a: assert property (
    state == ocd_pkg::ST_RUN && src_edge && divider_value > 14'h0001 && $stable(divider_value)
    |=> div_cnt < $past(divider_value))
    else $error("Divider count passed its value.");
  source_pick_a: assert property (
    divider_source_select == 2'h3 && state == ocd_pkg::ST_RUN && divider_value > 14'h0001
    && pin_s2[2] && !src_prev && div_cnt < 14'(divider_value - 14'h0001)
    && !(sync_rise && sync_participation) |=> div_cnt == 14'($past(div_cnt) + 14'h0001))
    else $error("Reference clock edge did not advance the divider.");
  sync_load_a: assert property (
    sync_rise && sync_participation && divider_value != 14'h0000
    |=> state == ocd_pkg::ST_HOLD && delay_cnt == $past(restart_delay_count) && !div_clk)
    else $error("Sync did not load the restart delay.");
  hold_release_a: assert property (
    state == ocd_pkg::ST_HOLD && delay_cnt == 5'h00 && divider_value != 14'h0000
    && !(sync_rise && sync_participation) |=> state == ocd_pkg::ST_RUN)
    else $error("Divider did not restart after the delay.");
  sync_ignore_a: assert property (
    state == ocd_pkg::ST_RUN && !sync_participation && divider_value != 14'h0000
    |=> state == ocd_pkg::ST_RUN)
    else $error("Sync disturbed a channel that does not take part.");
  silence_park_a: assert property (
    output_silence && buffer_format_select != 3'h0
    |=> OUT_TRUE_O == $past(parked_level_select) && OUT_COMP_O == !$past(parked_level_select))
    else $error("Silenced output not at the parked level.");
  silence_still_a: assert property (
    output_silence && $stable(reg_output) && buffer_format_select != 3'h0 |=> $stable(OUT_TRUE_O))
    else $error("Silenced output toggled.");
  polarity_true_a: assert property (
    !output_silence && buffer_format_select == 3'h5 && single_ended_polarity == 2'h2
    |=> OUT_TRUE_O == !$past(routed) && OUT_COMP_O == $past(routed))
    else $error("Single-ended polarity not applied.");
  format_leg_a: assert property (
    buffer_format_select == 3'h6 |=> TRUE_LEG_EN_O && !COMP_LEG_EN_O && BUFFER_FORMAT_O == 3'h6)
    else $error("True-leg-only format enabled the wrong legs.");
  route_one_a: assert property (
    !output_silence && output_source_route == 2'h0 && buffer_format_select == 3'h1
    |=> OUT_TRUE_O == $past(pin_s2[3]) && OUT_COMP_O == !$past(pin_s2[3]))
    else $error("Channel one clock not routed to the output.");
  nvm_load_a: assert property (
    NVM_LOAD_I && !REG_WR_I |=> divider_value == $past(NVM_DIVIDER_I))
    else $error("Page load did not reach the divider value.");

  hold_seen_c: cover property (state == ocd_pkg::ST_HOLD ##1 state == ocd_pkg::ST_RUN);
  divide_seen_c: cover property (divider_value == 14'h0004 && $rose(CH2_DIVIDED_O));
  silence_seen_c: cover property (output_silence && OUT_TRUE_O);
  power_seen_c: cover property ($fell(DIVIDER_POWERED_O));

endmodule

// *** ocd_pkg.sv ***
package ocd_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] ADDR_RESERVED_CONFIG = 8'h2A;
  localparam logic [7:0] ADDR_DIVIDER_SETUP = 8'h2B;
  localparam logic [7:0] ADDR_OUTPUT_SETUP = 8'h2C;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] RESET_RESERVED_CONFIG = 16'h0000;
  localparam logic [15:0] RESET_DIVIDER_SETUP = 16'h0000;
  localparam logic [15:0] RESET_OUTPUT_SETUP = 16'h0008;

  // ==========================================================================
  // Field positions and widths.
  localparam int RESERVED_EX_W = 9;
  localparam int SOURCE_SELECT_LSB = 14;
  localparam int DIVIDER_VALUE_LSB = 0;
  localparam int DIVIDER_VALUE_W = 14;
  localparam int RESTART_DELAY_LSB = 11;
  localparam int RESTART_DELAY_W = 5;
  localparam int SYNC_PARTICIPATION_BIT = 10;
  localparam int PARKED_LEVEL_BIT = 8;
  localparam int OUTPUT_SILENCE_BIT = 7;
  localparam int POLARITY_LSB = 5;
  localparam int FORMAT_LSB = 2;
  localparam int ROUTE_LSB = 0;

  // ==========================================================================
  // Encodings.
  typedef enum logic [1:0] {
    SRC_PRESCALER_FIRST = 2'h0,
    SRC_PRESCALER_SECOND = 2'h1,
    SRC_NONE = 2'h2,
    SRC_REFERENCE = 2'h3
  } ocd_source_t;

  typedef enum logic [2:0] {
    FMT_OFF = 3'h0,
    FMT_LVDS = 3'h1,
    FMT_HCSL = 3'h2,
    FMT_CML = 3'h3,
    FMT_LVPECL = 3'h4,
    FMT_SINGLE_ENDED_BOTH_LEGS = 3'h5,
    FMT_SINGLE_ENDED_TRUE_LEG = 3'h6,
    FMT_SINGLE_ENDED_COMPLEMENT_LEG = 3'h7
  } ocd_format_t;

  typedef enum logic [1:0] {
    ROUTE_CHANNEL_ONE = 2'h0,
    ROUTE_CHANNEL_TWO = 2'h1,
    ROUTE_CHANNEL_THREE = 2'h2,
    ROUTE_NONE = 2'h3
  } ocd_route_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } ocd_state_t;

endpackage

// *** testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and observation signals.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic nvm_load = 1'b0;
  logic [13:0] nvm_div = 14'h0000;
  logic [8:0] nvm_res = 9'h000;
  logic [2:0] src_on = 3'h0;
  logic [2:0] src_lvl = 3'h0;
  logic ch1 = 1'b0;
  logic ch3 = 1'b0;
  logic sync = 1'b0;
  logic [15:0] rdata;
  logic out_t, out_c, en_t, en_c, powered, divided;
  logic [2:0] fmt_o;
  int seed = 16;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int src_cnt = 0;

  ocd_channel_two dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata),
    .NVM_LOAD_I(nvm_load), .NVM_DIVIDER_I(nvm_div), .NVM_RESERVED_I(nvm_res),
    .PRESCALER_CLOCK_FIRST_I(src_lvl[0]), .PRESCALER_CLOCK_SECOND_I(src_lvl[1]),
    .REFERENCE_CLOCK_I(src_lvl[2]), .CH1_DIVIDED_I(ch1), .CH3_DIVIDED_I(ch3),
    .SYNC_I(sync),
    .OUT_TRUE_O(out_t), .OUT_COMP_O(out_c), .TRUE_LEG_EN_O(en_t),
    .COMP_LEG_EN_O(en_c), .BUFFER_FORMAT_O(fmt_o),
    .DIVIDER_POWERED_O(powered), .CH2_DIVIDED_O(divided)
  );

  // ==========================================================================
  // Clocks and watchdog.
  always #4 clk = ~clk;

  // Enabled source pins toggle every four core cycles, so one source period is 8 cycles.
  always @(negedge clk) begin
    src_cnt <= src_cnt + 1;
    if (src_cnt % 4 == 3) begin
      src_lvl <= src_lvl ^ src_on;
    end
  end

  // A hang is cut short well above the few thousand cycles the tests need.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      print_verdict();
    end
  end

  // ==========================================================================
  // Shared tasks and the model of the output stage.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Read data is registered on the strobe edge, so it is settled at the next falling edge.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  // Rises are counted on settled values only, one sample per falling edge.
  task automatic count_rises(input int n, input bit use_div, output int cnt);
    logic prev;
    logic cur;
    cnt = 0;
    prev = use_div ? divided : out_t;
    repeat (n) begin
      @(negedge clk);
      cur = use_div ? divided : out_t;
      if (cur === 1'b1 && prev === 1'b0) cnt++;
      prev = cur;
    end
  endtask

  // Returns leg enables and the levels of enabled legs; a disabled leg's level is returned as zero.
  function automatic logic [3:0] exp_out(input logic [2:0] f, input logic [1:0] p,
      input logic s, input logic k, input logic ck);
    logic et, ec, t, c;
    et = (f != 3'h0) && (f != 3'h7);
    ec = (f != 3'h0) && (f != 3'h6);
    t = (f >= 3'h5) ? ck ^ p[1] : ck;
    c = (f >= 3'h5) ? ck ^ p[0] : ~ck;
    if (s) begin
      t = k;
      c = ~k;
    end
    return {et, ec, t & et, c & ec};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [15:0] v2a, v2b, v;
    logic [2:0] f;
    logic [1:0] p, r;
    logic s, k, ck;
    int n, cnt;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd_reg(8'h2A, v);
    check(v, ocd_pkg::RESET_RESERVED_CONFIG);
    rd_reg(8'h2B, v);
    check(v, ocd_pkg::RESET_DIVIDER_SETUP);
    rd_reg(8'h2C, v);
    check(v, ocd_pkg::RESET_OUTPUT_SETUP);
    check({13'h0, fmt_o}, 16'h0002);
    check({15'h0, powered}, 16'h0000);
    $display("test reset values done");
    // Random words round-trip; an unmapped write must leave registers 2A and 2B alone.
    for (int i = 0; i < 8; i++) begin
      v2a = 16'($random(seed));
      v2b = 16'($random(seed));
      wr_reg(8'h2A, v2a);
      wr_reg(8'h2B, v2b);
      wr_reg(8'h2D, 16'($random(seed)));
      rd_reg(8'h2A, v);
      check(v, v2a);
      rd_reg(8'h2B, v);
      check(v, v2b);
    end
    rd_reg(8'h40, v);
    check(v, 16'h0000);
    nvm_div = 14'($random(seed));
    nvm_res = 9'($random(seed));
    nvm_load = 1'b1;
    @(negedge clk);
    nvm_load = 1'b0;
    rd_reg(8'h2A, v);
    check(v, {v2a[15:9], nvm_res});
    rd_reg(8'h2B, v);
    check(v, {v2b[15:14], nvm_div});
    $display("test register access done");
    // Hold the divider off so only the routed levels reach the legs.
    wr_reg(8'h2B, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      f = i[2:0];
      p = 2'($random(seed));
      s = (i >= 8) ? 1'($random(seed)) : 1'b0;
      k = 1'($random(seed));
      r = 2'($random(seed));
      if (r == 2'h1) r = 2'h3;
      ch1 = 1'($random(seed));
      ch3 = 1'($random(seed));
      ck = (r == 2'h0) ? ch1 : (r == 2'h2) ? ch3 : 1'b0;
      wr_reg(8'h2C, {7'h00, k, s, p, f, r});
      repeat (8) @(negedge clk);
      check({12'h0, en_t, en_c, out_t & en_t, out_c & en_c},
        {12'h0, exp_out(f, p, s, k, ck)});
      check({13'h0, fmt_o}, {13'h0, f});
    end
    $display("test output stage done");
    // Each source code in turn, the unused code last; own divided clock routed out.
    for (int j = 0; j < 4; j++) begin
      r = j[1:0];
      if (j == 2) r = 2'h3;
      if (j == 3) r = 2'h2;
      n = 1 + ($random(seed) & 3) + int'(j == 2); // The reference pass needs a real count.
      src_on = (r == 2'h0) ? 3'b001 : (r == 2'h1) ? 3'b010 : (r == 2'h3) ? 3'b100 : 3'b111;
      wr_reg(8'h2C, 16'h0009);
      wr_reg(8'h2B, {r, 14'(n)});
      count_rises(24, 1'b0, cnt);
      count_rises(80 * n, 1'b0, cnt);
      check(16'((r == 2'h2) ? cnt : (cnt >= 9 && cnt <= 11)), 16'(r != 2'h2));
      check({15'h0, powered}, 16'h0001);
    end
    wr_reg(8'h2B, 16'h0000);
    src_on = 3'b001;
    count_rises(16, 1'b1, cnt);
    count_rises(160, 1'b1, cnt);
    check(16'(cnt), 16'h0000);
    check({15'h0, powered}, 16'h0000);
    $display("test divider done");
    // A sync with an eight-period restart delay, with and without participation.
    for (int q = 0; q < 2; q++) begin
      wr_reg(8'h2B, 16'h0004);
      wr_reg(8'h2C, {5'h08, ~q[0], 10'h009});
      count_rises(80, 1'b1, cnt);
      sync = 1'b1;
      count_rises(5, 1'b1, cnt);
      count_rises(40, 1'b1, cnt);
      check(16'(cnt != 0), 16'(q == 1));
      count_rises(55, 1'b1, cnt);
      check(16'(cnt != 0), 16'h0001);
      sync = 1'b0;
    end
    $display("test sync done");
    print_verdict();
  end
endmodule
